//--- pkg/stn_pkg.sv
// holds register indices, reset values, ranges, timing and carrier structs.
// assumes a 50 MHz clock and a 32-bit ahb-lite register bus.
package stn_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_BANDWIDTH = 10'h23E;
	localparam logic [9:0] IDX_MODE = 10'h240;
	localparam logic [9:0] IDX_DONE = 10'h242;
	localparam logic [9:0] IDX_OVSPD = 10'h244;
	localparam logic [9:0] IDX_POSDEV = 10'h246;
	localparam logic [9:0] IDX_NF2 = 10'h256;
	localparam logic [9:0] IDX_ND2 = 10'h258;
	localparam logic [9:0] IDX_NF3 = 10'h25A;
	localparam logic [9:0] IDX_ND3 = 10'h25C;
	localparam logic [9:0] IDX_INERTIA = 10'h300;
	localparam logic [9:0] IDX_GAIN1 = 10'h301;
	localparam logic [9:0] IDX_GAIN3 = 10'h302;
	localparam logic [9:0] IDX_GAIN4 = 10'h303;
	localparam logic [9:0] IDX_GAINA = 10'h304;
	localparam logic [9:0] IDX_GAINB = 10'h305;
	localparam logic [9:0] IDX_STATUS = 10'h306;
	localparam int IDX_LSB = 2;
	// reset values
	localparam logic [15:0] RST_BANDWIDTH = 16'h0028;
	localparam logic [15:0] RST_OVSPD = 16'h1388;
	localparam logic [31:0] RST_POSDEV = 32'h003A_9800;
	localparam logic [15:0] RST_NFREQ = 16'h03E8;
	localparam logic [15:0] RST_NDEPTH = 16'h0000;
	localparam logic [15:0] RST_INERTIA = 16'h000A;
	localparam logic [15:0] RST_GAIN = 16'h0000;
	// legal ranges
	localparam logic [15:0] BW_MIN = 16'h0001;
	localparam logic [15:0] BW_MAX = 16'h03E8;
	localparam logic [15:0] OVSPD_MIN = 16'h0001;
	localparam logic [15:0] OVSPD_MAX = 16'h1388;
	localparam logic [31:0] POSDEV_MIN = 32'h0000_0001;
	localparam logic [31:0] POSDEV_MAX = 32'h07A1_2000;
	localparam logic [15:0] NF_MIN = 16'h0032;
	localparam logic [15:0] NF_MAX = 16'h07D0;
	localparam logic [15:0] ND_MAX = 16'h0020;
	localparam logic [15:0] DONE_MAX = 16'h0001;
	// inertia save period
	localparam longint CLK_HZ = 64'd50000000;
	localparam longint SAVE_MIN = 64'd30;
	localparam longint SAVE_CYC = SAVE_MIN * 64'd60 * CLK_HZ;
	localparam int TMR_W = 37;
	typedef enum logic [1:0] {MODE_MANUAL, MODE_AUTO, MODE_SEMI} stn_mode_e;
	// estimator results from the control core, same clock
	typedef struct packed {
		logic [15:0] inertia;
		logic stable;
		logic out_of_range;
		logic [15:0] gain1;
		logic [15:0] gain3;
		logic [15:0] gain4;
		logic [15:0] gaina;
		logic [15:0] gainb;
	} stn_est_s;
	// measured motion for the warnings
	typedef struct packed {
		logic [15:0] speed;
		logic [31:0] pos_err;
	} stn_meas_s;
	// settings driven into the control core
	typedef struct packed {
		logic [1:0] mode;
		logic estimating;
		logic [15:0] bandwidth;
		logic [15:0] inertia;
		logic [15:0] gain1;
		logic [15:0] gain3;
		logic [15:0] gain4;
		logic [15:0] gaina;
		logic [15:0] gainb;
		logic notch2_on;
		logic [15:0] notch2_freq;
		logic signed [7:0] notch2_db;
		logic notch3_on;
		logic [15:0] notch3_freq;
		logic signed [7:0] notch3_db;
		logic over_speed;
		logic pos_dev;
	} stn_tune_s;
endpackage

//--- logic/stn_tuning.sv
// tuning mode, supervision thresholds and notch settings behind ahb-lite.
// assumes estimator and measurement inputs come from logic on hclk.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
module stn_tuning #(
	parameter logic [stn_pkg::TMR_W-1:0] SAVE_CYCLES = stn_pkg::TMR_W'(stn_pkg::SAVE_CYC)
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// control core
	input wire stn_pkg::stn_est_s est,
	input wire stn_pkg::stn_meas_s meas,
	output stn_pkg::stn_tune_s tune
);
	import stn_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic ready;
		logic wr_pend;
		logic [9:0] wr_idx;
		logic [31:0] rdata;
		stn_mode_e mode;
		logic done;
		logic estimating;
		logic [15:0] bw;
		logic [15:0] inertia;
		logic [15:0] g1;
		logic [15:0] g3;
		logic [15:0] g4;
		logic [15:0] ga;
		logic [15:0] gb;
		logic [15:0] ovspd;
		logic [31:0] posdev;
		logic [15:0] nf2;
		logic [15:0] nd2;
		logic [15:0] nf3;
		logic [15:0] nd3;
		logic [TMR_W-1:0] tmr;
		logic over_speed;
		logic pos_dev;
		// notch gates and signed depths, held in flops so the core
		// never sees a decoded glitch when a depth write lands
		logic n2_on;
		logic signed [7:0] n2_db;
		logic n3_on;
		logic signed [7:0] n3_db;
	} stn_state_s;

	stn_state_s q;
	stn_state_s next_q;
	logic addr_ok;
	logic [9:0] addr_idx;
	logic [15:0] wlo;

	assign addr_ok = hsel && htrans[1] && hready;
	assign addr_idx = haddr[IDX_LSB+9:IDX_LSB];
	assign wlo = hwdata[15:0];

	// ****************************************
	// read mux
	// ****************************************
	// unmapped indices read zero; 16-bit values sit in the low half
	function automatic logic [31:0] rd_word(input stn_state_s s, input logic [9:0] idx);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (idx)
			IDX_BANDWIDTH: r = {16'h0000, s.bw};
			IDX_MODE: r = {30'h0000_0000, s.mode};
			IDX_DONE: r = {31'h0000_0000, s.done};
			IDX_OVSPD: r = {16'h0000, s.ovspd};
			IDX_POSDEV: r = s.posdev;
			IDX_NF2: r = {16'h0000, s.nf2};
			IDX_ND2: r = {16'h0000, s.nd2};
			IDX_NF3: r = {16'h0000, s.nf3};
			IDX_ND3: r = {16'h0000, s.nd3};
			IDX_INERTIA: r = {16'h0000, s.inertia};
			IDX_GAIN1: r = {16'h0000, s.g1};
			IDX_GAIN3: r = {16'h0000, s.g3};
			IDX_GAIN4: r = {16'h0000, s.g4};
			IDX_GAINA: r = {16'h0000, s.ga};
			IDX_GAINB: r = {16'h0000, s.gb};
			IDX_STATUS: r = {28'h000_0000, s.pos_dev, s.over_speed, s.estimating, s.done};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_q = q;
		next_q.ready = 1'b1;
		// zero-wait bus: capture writes, sample read data at the address phase
		next_q.wr_pend = addr_ok && hwrite;
		next_q.wr_idx = addr_idx;
		next_q.rdata = (addr_ok && !hwrite) ? rd_word(q, addr_idx) : 32'h0000_0000;

		// data-phase write; out-of-range values are dropped
		if (q.wr_pend) begin
			unique case (q.wr_idx)
				IDX_BANDWIDTH: if (wlo >= BW_MIN && wlo <= BW_MAX) next_q.bw = wlo;
				IDX_MODE: begin
					if (wlo <= 16'h0002 && stn_mode_e'(wlo[1:0]) != q.mode) begin
						next_q.mode = stn_mode_e'(wlo[1:0]);
						next_q.tmr = '0;
						if (wlo[1:0] == MODE_MANUAL) begin
							// refresh gains from the tuner on return to manual
							next_q.inertia = est.inertia;
							next_q.g1 = est.gain1;
							next_q.g3 = est.gain3;
							next_q.g4 = est.gain4;
							next_q.estimating = 1'b0;
							if (q.mode == MODE_SEMI) begin
								next_q.ga = est.gaina;
								next_q.gb = est.gainb;
							end
						end else if (wlo[1:0] == MODE_SEMI) begin
							next_q.done = 1'b0;
							next_q.estimating = 1'b1;
						end else begin
							next_q.estimating = 1'b1;
						end
					end
				end
				IDX_DONE: if (wlo <= DONE_MAX) next_q.done = wlo[0];
				IDX_OVSPD: if (wlo >= OVSPD_MIN && wlo <= OVSPD_MAX) next_q.ovspd = wlo;
				// full 32-bit threshold, the only register using the upper half
				IDX_POSDEV: begin
					if (hwdata >= POSDEV_MIN && hwdata <= POSDEV_MAX) begin
						next_q.posdev = hwdata;
					end
				end
				IDX_NF2: if (wlo >= NF_MIN && wlo <= NF_MAX) next_q.nf2 = wlo;
				IDX_ND2: if (wlo <= ND_MAX) next_q.nd2 = wlo;
				IDX_NF3: if (wlo >= NF_MIN && wlo <= NF_MAX) next_q.nf3 = wlo;
				IDX_ND3: if (wlo <= ND_MAX) next_q.nd3 = wlo;
				IDX_INERTIA: next_q.inertia = wlo;
				// gains are software-owned only in manual mode
				IDX_GAIN1: if (q.mode == MODE_MANUAL) next_q.g1 = wlo;
				IDX_GAIN3: if (q.mode == MODE_MANUAL) next_q.g3 = wlo;
				IDX_GAIN4: if (q.mode == MODE_MANUAL) next_q.g4 = wlo;
				IDX_GAINA: if (q.mode == MODE_MANUAL) next_q.ga = wlo;
				IDX_GAINB: if (q.mode == MODE_MANUAL) next_q.gb = wlo;
				default: ;
			endcase
		end

		// periodic inertia save in auto mode
		if (q.mode == MODE_AUTO) begin
			if (q.tmr >= SAVE_CYCLES - TMR_W'(1)) begin
				next_q.tmr = '0;
				next_q.inertia = est.inertia;
			end else begin
				next_q.tmr = q.tmr + TMR_W'(1);
			end
		end

		// semi-auto settle and re-arm; hardware beats a same-cycle software write, except a write to the mode register, which skips this update
		if (q.mode == MODE_SEMI && !(q.wr_pend && q.wr_idx == IDX_MODE)) begin
			if (est.out_of_range) begin
				next_q.done = 1'b0;
				next_q.estimating = 1'b1;
			end else if (q.estimating && est.stable) begin
				next_q.done = 1'b1;
				next_q.estimating = 1'b0;
				next_q.inertia = est.inertia;
			end
		end

		// warnings compare against the live thresholds
		next_q.over_speed = meas.speed > q.ovspd;
		next_q.pos_dev = meas.pos_err > q.posdev;

		// notch gates follow the depth that will stand after this edge,
		// so gate and depth always change together
		next_q.n2_on = next_q.nd2 != RST_NDEPTH;
		next_q.n2_db = -$signed({2'b00, next_q.nd2[5:0]});
		next_q.n3_on = next_q.nd3 != RST_NDEPTH;
		next_q.n3_db = -$signed({2'b00, next_q.nd3[5:0]});
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.mode <= MODE_MANUAL;
			q.bw <= RST_BANDWIDTH;
			q.inertia <= RST_INERTIA;
			q.g1 <= RST_GAIN;
			q.g3 <= RST_GAIN;
			q.g4 <= RST_GAIN;
			q.ga <= RST_GAIN;
			q.gb <= RST_GAIN;
			q.ovspd <= RST_OVSPD;
			q.posdev <= RST_POSDEV;
			q.nf2 <= RST_NFREQ;
			q.nd2 <= RST_NDEPTH;
			q.nf3 <= RST_NFREQ;
			q.nd3 <= RST_NDEPTH;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// ready is low from reset until the first clock edge after reset is released
	assign hreadyout = q.ready;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;

	// the core sees settings straight from the state flops
	always_comb begin
		tune.mode = q.mode;
		tune.estimating = q.estimating;
		tune.bandwidth = q.bw;
		tune.inertia = q.inertia;
		tune.gain1 = q.g1;
		tune.gain3 = q.g3;
		tune.gain4 = q.g4;
		tune.gaina = q.ga;
		tune.gainb = q.gb;
		tune.notch2_on = q.n2_on;
		tune.notch2_freq = q.nf2;
		tune.notch2_db = q.n2_db;
		tune.notch3_on = q.n3_on;
		tune.notch3_freq = q.nf3;
		tune.notch3_db = q.n3_db;
		tune.over_speed = q.over_speed;
		tune.pos_dev = q.pos_dev;
	end
endmodule

//--- testbench/stn_tuning_properties.sv
// concurrent checks on the tuning block ports.
// assumes it is bound onto every stn_tuning instance.
`timescale 1ns/1ns
module stn_tuning_properties
	import stn_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus and core side
	input wire logic hreadyout,
	input wire logic hresp,
	input wire stn_pkg::stn_est_s est,
	input wire stn_pkg::stn_tune_s tune
);
	// ****
	// mode steps and port checks
	// ****
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence leave_auto;
		$past(tune.mode) == MODE_AUTO && tune.mode == MODE_MANUAL;
	endsequence
	sequence leave_semi;
		$past(tune.mode) == MODE_SEMI && tune.mode == MODE_MANUAL;
	endsequence
	// mode must stay semi on both edges, a mode write would skip the update
	sequence semi_hold(c);
		tune.mode == MODE_SEMI && c ##1 tune.mode == MODE_SEMI;
	endsequence
	a_okay_resp: assert property (hresp == 1'b0) else $error("error response");
	a_ready_run: assert property ($past(hresetn) |-> hreadyout) else $error("wait state");
	a_mode_legal: assert property (tune.mode <= 2'h2) else $error("bad mode");
	a_notch2_gate: assert property (tune.notch2_on == (tune.notch2_db != 8'sh0))
		else $error("notch2 gate");
	a_notch3_gate: assert property (tune.notch3_on == (tune.notch3_db != 8'sh0))
		else $error("notch3 gate");
	a_depth_sign: assert property (tune.notch2_db <= 8'sh0 && tune.notch3_db >= -8'sh20)
		else $error("depth sign");
	a_freq_range: assert property (tune.notch2_freq inside {[NF_MIN:NF_MAX]})
		else $error("notch2 freq");
	a_auto_copy: assert property (leave_auto |-> tune.gain1 == $past(est.gain1)
		&& tune.gain4 == $past(est.gain4) && tune.inertia == $past(est.inertia))
		else $error("auto copy");
	a_semi_copy: assert property (leave_semi |-> tune.gaina == $past(est.gaina)
		&& tune.gainb == $past(est.gainb) && tune.gain3 == $past(est.gain3))
		else $error("semi copy");
	a_semi_entry: assert property ($past(tune.mode) != MODE_SEMI
		&& tune.mode == MODE_SEMI |-> tune.estimating) else $error("no restart");
	a_semi_stable: assert property (semi_hold(est.stable && !est.out_of_range)
		|-> !tune.estimating) else $error("still estimating");
	a_semi_resume: assert property (semi_hold(est.out_of_range) |-> tune.estimating)
		else $error("no resume");
	a_auto_save: assert property ($past(tune.mode) == MODE_AUTO && tune.mode == MODE_AUTO
		&& $changed(tune.inertia) |-> tune.inertia == $past(est.inertia)) else $error("save");
endmodule
bind stn_tuning stn_tuning_properties chk (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .est(est), .tune(tune));

//--- testbench/stn_core_model.sv
// control core stand-in driving estimator results and motion.
// assumes the bench sets its knobs just after a clock edge.
`timescale 1ns/1ns
module stn_core_model
	import stn_pkg::*;
(
	// clock
	input wire logic hclk,
	// knobs from the bench
	input wire logic [15:0] seed,
	input wire logic stable,
	input wire logic oor,
	input wire logic [47:0] motion,
	// toward the block
	output stn_pkg::stn_est_s est,
	output stn_pkg::stn_meas_s meas
);
	// registered like a real core, so results land one edge late
	always_ff @(posedge hclk) begin
		est <= {seed, stable, oor, seed + 16'h1, seed + 16'h3, seed + 16'h4,
			seed + 16'h5, seed + 16'h6};
		meas <= motion;
	end
endmodule

//--- testbench/stn_tuning_bench.sv
// self-checking bench for the tuning block with a register model.
// assumes a short save period parameter keeps the run brief.
`timescale 1ns/1ns
module stn_tuning_bench;
	import stn_pkg::*;
	localparam int SAVE = 20;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp;
	logic [31:0] hrdata, rd;
	logic [15:0] seed = 16'h0;
	logic stable = 1'b0;
	logic oor = 1'b0;
	logic [47:0] motion = 48'h0;
	stn_est_s est;
	stn_meas_s meas;
	stn_tune_s tune;
	int mismatches = 0;
	int cmp_count = 0;
	int m[int], lo[int], hi[int];
	int i, v;
	int ids[8] = '{IDX_BANDWIDTH, IDX_DONE, IDX_OVSPD, IDX_POSDEV, IDX_NF2, IDX_ND2, IDX_NF3,
		IDX_ND3};
	// ****
	// harness
	// ****
	always #10 hclk = ~hclk;
	stn_tuning #(.SAVE_CYCLES(TMR_W'(SAVE))) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.est(est), .meas(meas), .tune(tune));
	stn_core_model core (.hclk(hclk), .seed(seed), .stable(stable), .oor(oor),
		.motion(motion), .est(est), .meas(meas));
	task automatic results();
		if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// address phase held until ready, then data phase; read data taken at its end
	task automatic bus(input logic w, input int a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= 32'(a) << IDX_LSB;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input int a, input int e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// the model drops writes outside the legal range
	task automatic wr(input int a, input int d);
		bus(1'b1, a, d);
		if (d >= lo[a] && d <= hi[a]) m[a] = d;
	endtask
	function automatic void setr(input int a, input int r, input int l, input int h);
		m[a] = r;
		lo[a] = l;
		hi[a] = h;
	endfunction
	// watchdog far beyond the few hundred cycles of the run
	initial begin
		repeat (5000) @(posedge hclk);
		mismatches++;
		results();
	end
	// ****
	// scenarios
	// ****
	initial begin
		void'($urandom(88409));
		setr(IDX_BANDWIDTH, 32'h28, 32'h1, 32'h3E8);
		setr(IDX_DONE, 32'h0, 32'h0, 32'h1);
		setr(IDX_OVSPD, 32'h1388, 32'h1, 32'h1388);
		setr(IDX_POSDEV, 32'h003A_9800, 32'h1, 32'h07A1_2000);
		setr(IDX_NF2, 32'h3E8, 32'h32, 32'h7D0);
		setr(IDX_ND2, 32'h0, 32'h0, 32'h20);
		setr(IDX_NF3, 32'h3E8, 32'h32, 32'h7D0);
		setr(IDX_ND3, 32'h0, 32'h0, 32'h20);
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (ids[k]) rdc(ids[k], m[ids[k]]);
		rdc(IDX_MODE, 32'h0);
		rdc(32'h3FF, 32'h0);
		// both edges of each range, one past each, then a random legal value
		foreach (ids[k]) begin
			i = ids[k];
			for (int j = 0; j < 5; j++) begin
				v = j < 2 ? lo[i] - 1 + j : j < 4 ? hi[i] + j - 2 : lo[i] + $urandom % (hi[i] - lo[i] + 1);
				wr(i, v);
				rdc(i, m[i]);
			end
		end
		chk(tune.notch2_freq, m[IDX_NF2]);
		chk(tune.notch2_on, m[IDX_ND2] != 0);
		chk(tune.notch2_db, -m[IDX_ND2]);
		chk(tune.notch3_freq, m[IDX_NF3]);
		chk(tune.notch3_db, -m[IDX_ND3]);
		chk(tune.notch3_on, m[IDX_ND3] != 0);
		for (int j = 0; j < 2; j++) begin
			motion <= {16'(m[IDX_OVSPD] + j), 32'(m[IDX_POSDEV] + j)};
			repeat (3) @(posedge hclk);
			chk(tune.over_speed, j);
			chk(tune.pos_dev, j);
		end
		bus(1'b1, IDX_GAIN1, 32'h1234);
		rdc(IDX_GAIN1, 32'h1234);
		bus(1'b1, IDX_INERTIA, 32'h50);
		seed <= 16'h0100;
		bus(1'b1, IDX_MODE, 32'h1);
		bus(1'b1, IDX_GAIN1, 32'h5555);
		rdc(IDX_GAIN1, 32'h1234);
		rdc(IDX_INERTIA, 32'h50);
		repeat (SAVE) @(posedge hclk);
		rdc(IDX_INERTIA, 32'h100);
		chk(tune.bandwidth, m[IDX_BANDWIDTH]);
		bus(1'b1, IDX_MODE, 32'h0);
		rdc(IDX_GAIN3, 32'h103);
		rdc(IDX_GAINA, 32'h0);
		rdc(IDX_INERTIA, 32'h100);
		seed <= 16'h0200;
		bus(1'b1, IDX_MODE, 32'h2);
		stable <= 1'b1;
		repeat (3) @(posedge hclk);
		rdc(IDX_DONE, 32'h1);
		rdc(IDX_INERTIA, 32'h200);
		oor <= 1'b1;
		repeat (3) @(posedge hclk);
		rdc(IDX_DONE, 32'h0);
		chk(tune.estimating, 1);
		bus(1'b1, IDX_MODE, 32'h0);
		rdc(IDX_GAINB, 32'h206);
		bus(1'b1, IDX_MODE, 32'h3);
		rdc(IDX_MODE, 32'h0);
		results();
	end
endmodule
